// ==== core/mdv_pkg.sv ====
// shared constants and types of the multiply/divide co-processor
// assumes a single 100 MHz system clock and a classic wishbone master
package mdv_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned WB_AW = 10;
   localparam int unsigned WB_DW = 32;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_OPB0 = 8'hE9;
   localparam logic [7:0] IDX_OPB1 = 8'hEA;
   localparam logic [7:0] IDX_OPB2 = 8'hEB;
   localparam logic [7:0] IDX_OPB3 = 8'hEC;
   localparam logic [7:0] IDX_OPB4 = 8'hED;
   localparam logic [7:0] IDX_OPB5 = 8'hEE;
   localparam logic [7:0] IDX_CTRL = 8'hEF;

   // ----------------------------------------------------------------
   // arith_control fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_ERR_BIT = 7;
   localparam int unsigned CTRL_OV_BIT  = 6;
   localparam int unsigned CTRL_DIR_BIT = 5;
   localparam int unsigned CNT_W        = 5;
   localparam logic [7:0]  OPB_RST      = 8'h00;
   localparam logic [7:0]  CTRL_RST     = 8'h00;

   // ----------------------------------------------------------------
   // execution times in clock cycles
   // ----------------------------------------------------------------
   localparam logic [4:0] LAT_DIV32    = 5'h11;
   localparam logic [4:0] LAT_DIV16    = 5'h09;
   localparam logic [4:0] LAT_MUL      = 5'h0B;
   localparam logic [4:0] LAT_SHIFT_LO = 5'h03;
   localparam logic [4:0] LAT_NORM_LO  = 5'h04;

   // ----------------------------------------------------------------
   // arithmetic limits
   // ----------------------------------------------------------------
   localparam logic [31:0] MUL_OV_LIMIT = 32'h0000FFFF;
   localparam logic [31:0] DIV0_QUOT    = 32'hFFFFFFFF;
   localparam logic [5:0]  LZ_ALL_ZERO  = 6'h20;
   localparam logic [4:0]  NORM_MAX     = 5'h1F;

   // ----------------------------------------------------------------
   // carriers and enumerations
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [WB_AW-1:0]  adr;
      logic [3:0]        sel;
      logic [WB_DW-1:0]  dat;
   } mdv_wb_req_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] idx;
      logic [7:0] wdat;
   } mdv_acc_t;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_EXEC, SEQ_RESULT} mdv_seq_t;
   typedef enum logic [2:0] {OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} mdv_op_t;

endpackage : mdv_pkg

// ==== core/mdv_lead_zero.sv ====
// leading-zero counter for the normalize operation
// assumes a purely combinational use inside one clock domain
module mdv_lead_zero
   import mdv_pkg::*;
(
   // value
   input  wire logic [31:0] i_val,
   // result
   output logic      [5:0]  o_count
);

   logic [31:0] hit;

   // ----------------------------------------------------------------
   // first one from the top
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_hit
         if (g == 31) begin : g_top
            assign hit[g] = i_val[g];
         end else begin : g_low
            assign hit[g] = i_val[g] & ~(|i_val[31:g+1]);
         end
      end
   endgenerate

   always_comb begin
      o_count = LZ_ALL_ZERO;
      for (int k = 0; k < 32; k++) begin
         if (hit[k]) begin
            o_count = 6'(31 - k);
         end
      end
   end

endmodule : mdv_lead_zero

// ==== core/mdv_wb_slave.sv ====
// classic wishbone slave front end with a registered one-cycle ack
// assumes the master holds its request until ack and releases after it
module mdv_wb_slave
   import mdv_pkg::*;
(
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   // bus side
   input  wire mdv_wb_req_t       i_wb,
   output logic                   o_wb_ack,
   output logic      [WB_DW-1:0]  o_wb_dat,
   // register side
   input  wire logic [7:0]        i_rd_byte,
   output mdv_acc_t               o_acc
);

   logic              ack_q;
   logic [WB_DW-1:0]  dat_q;
   logic              take;
   logic              mapped;
   logic [7:0]        idx;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign idx    = i_wb.adr[WB_AW-1:2];
   assign take   = i_wb.cyc & i_wb.stb & ~ack_q;
   assign mapped = (idx >= IDX_OPB0) && (idx <= IDX_CTRL) && i_wb.sel[0];

   always_comb begin
      o_acc.rd   = take & ~i_wb.we & mapped;
      o_acc.wr   = take & i_wb.we & mapped;
      o_acc.idx  = idx;
      o_acc.wdat = i_wb.dat[7:0];
   end

   // ----------------------------------------------------------------
   // answer
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         dat_q <= '0;
      end else if (take) begin
         dat_q <= o_acc.rd ? {24'h000000, i_rd_byte} : 32'h00000000;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = dat_q;

endmodule : mdv_wb_slave

// ==== core/mdv_muldiv_unit.sv ====
// multiply/divide/shift/normalize co-processor behind a wishbone slave
// assumes one 100 MHz clock, synchronous active-low reset, 8-bit registers
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
module mdv_muldiv_unit
   import mdv_pkg::*;
(
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   // wishbone slave
   input  wire mdv_wb_req_t       i_wb,
   output logic                   o_wb_ack,
   output logic      [WB_DW-1:0]  o_wb_dat,
   // status
   output logic                   o_busy
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]        opb_q [6];
   logic              dir_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              err_q;
   logic              ov_q;
   logic              armed_q;
   mdv_seq_t          seq_q;
   mdv_op_t           op_q;
   logic              hi_q;
   logic              div16_q;
   logic [4:0]        tmr_q;
   logic              busy_q;

   mdv_acc_t          acc;
   logic [7:0]        rd_byte;
   logic [2:0]        opb_sel;
   logic              in_seq;
   logic              exec;
   logic              commit;
   logic              final_rd;
   logic              is_wr_opb;
   logic [5:0]        lz;
   logic [4:0]        nshift;
   logic [4:0]        lat_norm;
   logic [4:0]        lat_shift;
   logic [31:0]       val32;
   logic [15:0]       dvs;
   logic [15:0]       dvd16;
   logic [31:0]       res32;
   logic [15:0]       rem16;
   logic              ov_calc;
   logic [31:0]       prod;

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   mdv_wb_slave u_slave (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_wb      (i_wb),
      .o_wb_ack  (o_wb_ack),
      .o_wb_dat  (o_wb_dat),
      .i_rd_byte (rd_byte),
      .o_acc     (acc)
   );

   assign opb_sel   = 3'(acc.idx - IDX_OPB0);
   assign is_wr_opb = acc.wr && (acc.idx != IDX_CTRL);
   assign exec      = (seq_q == SEQ_EXEC);
   assign in_seq    = (seq_q == SEQ_LOAD) || exec;

   always_comb begin
      if (acc.idx == IDX_CTRL) begin
         rd_byte = {err_q, ov_q, dir_q, cnt_q};
      end else begin
         rd_byte = opb_q[opb_sel];
      end
   end

   // ----------------------------------------------------------------
   // operand views
   // ----------------------------------------------------------------
   assign val32 = {opb_q[3], opb_q[2], opb_q[1], opb_q[0]};
   assign dvs   = {opb_q[5], opb_q[4]};
   assign dvd16 = {opb_q[1], opb_q[0]};
   assign prod  = {16'h0000, dvd16} * {16'h0000, dvs};

   mdv_lead_zero u_lz (
      .i_val   (val32),
      .o_count (lz)
   );

   // an all-zero value can never reach a set top bit; stop at the field limit
   assign nshift = (lz == LZ_ALL_ZERO) ? NORM_MAX : lz[4:0];

   // two shift steps per cycle beyond the fixed overhead
   assign lat_shift = LAT_SHIFT_LO + ((acc.wdat[4:0] - 5'h01) >> 1);
   assign lat_norm  = (nshift == 5'h00) ? LAT_NORM_LO
                                        : LAT_NORM_LO + ((nshift - 5'h01) >> 1);

   // ----------------------------------------------------------------
   // result computation
   // ----------------------------------------------------------------
   always_comb begin
      res32   = val32;
      rem16   = dvs;
      ov_calc = 1'b0;
      case (op_q)
         OP_DIV32: begin
            if (dvs == 16'h0000) begin
               res32   = DIV0_QUOT;
               rem16   = dvd16;
               ov_calc = 1'b1;
            end else begin
               res32 = val32 / {16'h0000, dvs};
               rem16 = 16'(val32 % {16'h0000, dvs});
            end
         end
         OP_DIV16: begin
            res32 = {opb_q[3], opb_q[2], 16'h0000};
            if (dvs == 16'h0000) begin
               res32[15:0] = DIV0_QUOT[15:0];
               rem16       = dvd16;
               ov_calc     = 1'b1;
            end else begin
               res32[15:0] = dvd16 / dvs;
               rem16       = dvd16 % dvs;
            end
         end
         OP_MUL: begin
            res32   = prod;
            ov_calc = prod > MUL_OV_LIMIT;
         end
         OP_SHIFT: begin
            res32 = dir_q ? (val32 >> cnt_q) : (val32 << cnt_q);
         end
         OP_NORM: begin
            res32   = val32 << nshift;
            ov_calc = val32[31];
         end
         default: begin
            res32 = val32;
         end
      endcase
   end

   // a write in the last cycle aborts, so no result lands on it
   assign commit   = exec && (tmr_q == 5'h01) && !acc.wr;
   assign final_rd = acc.rd && (seq_q == SEQ_RESULT) &&
                     (((op_q == OP_DIV32) || (op_q == OP_DIV16)) ? (acc.idx == IDX_OPB5)
                                                                 : (acc.idx == IDX_OPB3));

   // ----------------------------------------------------------------
   // operand bytes
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 6; k++) begin
            opb_q[k] <= OPB_RST;
         end
      end else if (is_wr_opb) begin
         opb_q[opb_sel] <= acc.wdat;
      end else if (commit) begin
         {opb_q[3], opb_q[2], opb_q[1], opb_q[0]} <= res32;
         if ((op_q == OP_DIV32) || (op_q == OP_DIV16)) begin
            {opb_q[5], opb_q[4]} <= rem16;
         end
      end
   end

   // ----------------------------------------------------------------
   // control register: direction and count
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         dir_q <= CTRL_RST[CTRL_DIR_BIT];
         cnt_q <= CTRL_RST[CNT_W-1:0];
      end else if (acc.wr && (acc.idx == IDX_CTRL)) begin
         dir_q <= acc.wdat[CTRL_DIR_BIT];
         cnt_q <= acc.wdat[CNT_W-1:0];
      end else if (commit && (op_q == OP_NORM)) begin
         cnt_q <= nshift;
      end
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         err_q <= CTRL_RST[CTRL_ERR_BIT];
      end else if ((acc.wr && exec) || (acc.rd && exec && armed_q)) begin
         err_q <= 1'b1;
      end else if (acc.rd && (acc.idx == IDX_CTRL)) begin
         err_q <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ov_q <= CTRL_RST[CTRL_OV_BIT];
      end else if (commit) begin
         ov_q <= ov_calc;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         armed_q <= 1'b0;
      end else if (acc.wr && (acc.idx == IDX_OPB0)) begin
         armed_q <= 1'b1;
      end else if (final_rd) begin
         armed_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sequence tracking and execution timer
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         seq_q   <= SEQ_IDLE;
         op_q    <= OP_MUL;
         hi_q    <= 1'b0;
         div16_q <= 1'b0;
         tmr_q   <= 5'h00;
         busy_q  <= 1'b0;
      end else if (acc.wr) begin
         case (acc.idx)
            IDX_OPB0: begin
               seq_q   <= SEQ_LOAD;
               hi_q    <= 1'b0;
               div16_q <= 1'b0;
               busy_q  <= 1'b0;
            end
            IDX_OPB2, IDX_OPB3: begin
               if (in_seq) begin
                  seq_q  <= SEQ_LOAD;
                  hi_q   <= 1'b1;
                  busy_q <= 1'b0;
               end
            end
            IDX_OPB1, IDX_OPB4: begin
               if (in_seq) begin
                  seq_q   <= SEQ_LOAD;
                  div16_q <= (acc.idx == IDX_OPB4);
                  busy_q  <= 1'b0;
               end
            end
            IDX_OPB5: begin
               if (in_seq) begin
                  seq_q  <= SEQ_EXEC;
                  busy_q <= 1'b1;
                  if (hi_q) begin
                     op_q  <= OP_DIV32;
                     tmr_q <= LAT_DIV32;
                  end else if (div16_q) begin
                     op_q  <= OP_DIV16;
                     tmr_q <= LAT_DIV16;
                  end else begin
                     op_q  <= OP_MUL;
                     tmr_q <= LAT_MUL;
                  end
               end
            end
            IDX_CTRL: begin
               if (in_seq) begin
                  seq_q  <= SEQ_EXEC;
                  busy_q <= 1'b1;
                  if (acc.wdat[CNT_W-1:0] == 5'h00) begin
                     op_q  <= OP_NORM;
                     tmr_q <= lat_norm;
                  end else begin
                     op_q  <= OP_SHIFT;
                     tmr_q <= lat_shift;
                  end
               end
            end
            default: begin
               seq_q <= seq_q;
            end
         endcase
      end else if (exec) begin
         tmr_q <= tmr_q - 5'h01;
         if (tmr_q == 5'h01) begin
            seq_q  <= SEQ_RESULT;
            busy_q <= 1'b0;
         end
      end else if (final_rd) begin
         seq_q <= SEQ_IDLE;
      end
   end

   assign o_busy = busy_q;

endmodule : mdv_muldiv_unit

// ==== bench/mdv_muldiv_unit_monitor.sv ====
// port checker of the multiply/divide co-processor
// assumes classic single wishbone cycles and a bind to mdv_muldiv_unit
module mdv_muldiv_unit_monitor
   import mdv_pkg::*;
(
   // clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst_n,
   // watched ports
   input  wire mdv_wb_req_t      i_wb,
   input  wire logic             o_wb_ack,
   input  wire logic [WB_DW-1:0] o_wb_dat,
   input  wire logic             o_busy
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   logic take;

   assign take = i_wb.cyc & i_wb.stb & ~o_wb_ack;

   AST_ACK_NEXT: assert property (take |=> o_wb_ack)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   AST_DAT_HOLD: assert property (!o_wb_ack |-> $stable(o_wb_dat))
      else $error("read data moved without ack");
   AST_DAT_BYTE: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
      else $error("read data upper bits set");
   AST_START_BY_WRITE: assert property ($rose(o_busy) |-> $past(take & i_wb.we))
      else $error("busy rose without a write");
   AST_BUSY_MIN: assert property ($rose(o_busy) |-> o_busy[*3])
      else $error("operation shorter than three cycles");
   AST_BUSY_MAX: assert property ($rose(o_busy) |-> ##[3:19] !o_busy)
      else $error("operation longer than nineteen cycles");
   AST_READ_NO_START: assert property (take & !i_wb.we & !o_busy |=> !o_busy)
      else $error("read started an operation");
   AST_UNMAPPED_IDLE: assert property (take & (i_wb.adr[9:2] < IDX_OPB0) & !o_busy |=> !o_busy)
      else $error("unmapped write started an operation");

   cover property ($rose(o_busy));
   cover property (take & i_wb.we & o_busy);
   cover property (take & !i_wb.we & o_busy);
endmodule : mdv_muldiv_unit_monitor

bind mdv_muldiv_unit mdv_muldiv_unit_monitor u_mon (
   .i_sys_clk(i_sys_clk),
   .i_rst_n  (i_rst_n),
   .i_wb     (i_wb),
   .o_wb_ack (o_wb_ack),
   .o_wb_dat (o_wb_dat),
   .o_busy   (o_busy)
);

// ==== bench/mdv_core_model.sv ====
// processor core model issuing single classic wishbone cycles
// assumes the slave acks each request; a missing ack is reported back
module mdv_core_model
   import mdv_pkg::*;
(
   // clock
   input  wire logic             i_sys_clk,
   // slave answer
   input  wire logic             i_wb_ack,
   input  wire logic [WB_DW-1:0] i_wb_dat,
   // request
   output mdv_wb_req_t           o_wb
);
   timeunit 1ns;
   timeprecision 1ns;

   initial o_wb = '0;

   // request held until ack is sampled, then released for a cycle
   task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] wdat,
                         output logic [7:0] rdat, output logic ok);
      int n;
      ok = 1'b0;
      rdat = 8'h00;
      @(posedge i_sys_clk);
      o_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h000000, wdat}};
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge i_sys_clk);
         if (i_wb_ack === 1'b1) begin
            ok = 1'b1;
            rdat = i_wb_dat[7:0];
         end
      end
      o_wb <= '0;
   endtask : access
endmodule : mdv_core_model

// ==== bench/tb_mdv_muldiv_unit.sv ====
// self-checking bench of the multiply/divide co-processor
// assumes the core model drives the bus and the monitor is bound
module tb_mdv_muldiv_unit
   import mdv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic             i_sys_clk = 1'b0;
   logic             i_rst_n   = 1'b0;
   mdv_wb_req_t      wb;
   logic             ack;
   logic             busy;
   logic [WB_DW-1:0] rdat32;
   int               n_mismatch   = 0;
   int               total_checks = 0;
   int               busy_cnt     = 0;

   always #5 i_sys_clk = ~i_sys_clk;

   always @(posedge i_sys_clk) begin
      if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
   end

   mdv_muldiv_unit u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb(wb), .o_wb_ack(ack),
                          .o_wb_dat(rdat32), .o_busy(busy));
   mdv_core_model u_core (.i_sys_clk(i_sys_clk), .i_wb_ack(ack), .i_wb_dat(rdat32), .o_wb(wb));

   task automatic finish_test(input bit hung);
      if (hung) n_mismatch++;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] x;
      logic       ok;
      u_core.access(1'b1, idx, d, x, ok);
      if (!ok) finish_test(1);
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      logic ok;
      u_core.access(1'b0, idx, 8'h00, d, ok);
      if (!ok) finish_test(1);
   endtask : rd

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      rd(idx, d);
      check({24'h000000, d}, {24'h000000, exp});
   endtask : rdc

   // wait for the end of a started operation and check its length
   task automatic run_wait(input int n);
      for (int k = 0; k < 40 && busy !== 1'b0; k++) @(posedge i_sys_clk);
      if (busy !== 1'b0) finish_test(1);
      check(32'(busy_cnt), 32'(n));
   endtask : run_wait

   task automatic do_reset();
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
   endtask : do_reset

   task automatic t_reset();
      wr(8'h10, 8'hFF);
      rdc(8'h10, 8'h00);
      for (int i = 0; i < 7; i++) rdc(IDX_OPB0 + 8'(i), 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] p;
      p = {16'h0000, a} * {16'h0000, b};
      wr(IDX_OPB0, a[7:0]);
      wr(IDX_OPB4, b[7:0]);
      wr(IDX_OPB1, a[15:8]);
      busy_cnt = 0;
      wr(IDX_OPB5, b[15:8]);
      run_wait(11);
      rdc(IDX_CTRL, {1'b0, p > MUL_OV_LIMIT, 6'h00});
      for (int i = 0; i < 4; i++) rdc(IDX_OPB0 + 8'(i), p[8*i +: 8]);
      $display("test mul done");
   endtask : t_mul

   task automatic t_div(input logic [31:0] n, input logic [15:0] d, input bit wide);
      logic [31:0] q;
      logic [15:0] m;
      if (!wide) n[31:16] = 16'h0000;
      q = (d == 16'h0000) ? DIV0_QUOT : n / {16'h0000, d};
      m = (d == 16'h0000) ? n[15:0] : 16'(n % {16'h0000, d});
      wr(IDX_OPB0, n[7:0]);
      wr(IDX_OPB1, n[15:8]);
      if (wide) begin
         wr(IDX_OPB2, n[23:16]);
         wr(IDX_OPB3, n[31:24]);
      end
      wr(IDX_OPB4, d[7:0]);
      busy_cnt = 0;
      wr(IDX_OPB5, d[15:8]);
      run_wait(wide ? 17 : 9);
      rdc(IDX_CTRL, {1'b0, d == 16'h0000, 6'h00});
      for (int i = 0; i < (wide ? 4 : 2); i++) rdc(IDX_OPB0 + 8'(i), q[8*i +: 8]);
      rdc(IDX_OPB4, m[7:0]);
      rdc(IDX_OPB5, m[15:8]);
      $display("test div done");
   endtask : t_div

   // a zero count runs a normalize instead of a shift
   task automatic t_sh(input logic [31:0] v, input logic right, input logic [4:0] cnt);
      logic [31:0] e;
      logic [4:0]  s;
      int          lat;
      e = right ? v >> cnt : v << cnt;
      s = cnt;
      if (cnt == 5'h00) begin
         e = v;
         while (s < NORM_MAX && !e[31]) begin
            e = e << 1;
            s++;
         end
      end
      lat = (cnt != 5'h00) ? 3 + (int'(cnt) - 1) / 2 : 4 + ((s != 5'h00) ? (int'(s) - 1) / 2 : 0);
      for (int i = 0; i < 4; i++) wr(IDX_OPB0 + 8'(i), v[8*i +: 8]);
      busy_cnt = 0;
      wr(IDX_CTRL, {2'b11, right, cnt});
      run_wait(lat);
      rdc(IDX_CTRL, {1'b0, cnt == 5'h00 && v[31], right, s});
      for (int i = 0; i < 4; i++) rdc(IDX_OPB0 + 8'(i), e[8*i +: 8]);
      $display("test shift done");
   endtask : t_sh

   task automatic t_err();
      logic [7:0] c;
      wr(IDX_OPB0, 8'h03);
      wr(IDX_OPB4, 8'h05);
      wr(IDX_OPB1, 8'h00);
      wr(IDX_OPB5, 8'h00);
      rd(IDX_OPB2, c);
      check({31'h0, busy}, 32'h1);
      wr(IDX_OPB0, 8'h07);
      rd(IDX_CTRL, c);
      check({31'h0, c[7]}, 32'h1);
      rd(IDX_CTRL, c);
      check({31'h0, c[7]}, 32'h0);
      // an armed read during execution flags an error but lets the product finish
      wr(IDX_OPB0, 8'h03);
      wr(IDX_OPB4, 8'h05);
      wr(IDX_OPB1, 8'h00);
      busy_cnt = 0;
      wr(IDX_OPB5, 8'h00);
      rd(IDX_OPB2, c);
      run_wait(11);
      rdc(IDX_CTRL, 8'h80);
      rdc(IDX_OPB0, 8'h0F);
      rdc(IDX_OPB3, 8'h00);
      $display("test error done");
   endtask : t_err

   initial begin
      do_reset();
      t_reset();
      t_mul(16'h1234, 16'h5678);
      t_mul(16'h00FF, 16'h0100);
      t_mul(16'hFFFF, 16'hFFFF);
      t_div(32'h89ABCDEF, 16'h0123, 1'b1);
      t_div(32'h89ABCDEF, 16'h0000, 1'b1);
      t_div(32'h00001234, 16'h0007, 1'b0);
      t_div(32'h0000FFFF, 16'h0000, 1'b0);
      t_sh(32'h80000001, 1'b1, 5'h01);
      t_sh(32'h80000001, 1'b0, 5'h1F);
      t_sh(32'hF00000F0, 1'b1, 5'h1F);
      t_sh(32'h00012345, 1'b0, 5'h00);
      t_sh(32'h00000000, 1'b0, 5'h00);
      t_sh(32'h80000000, 1'b0, 5'h00);
      t_err();
      do_reset();
      t_reset();
      finish_test(0);
   end
endmodule : tb_mdv_muldiv_unit
